// ===== ssw_supervisor.sv
// Supply supervisor with power-on reset delay, watchdog and supply flags
`timescale 1ns/1ps
module ssw_supervisor
	import ssw_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT,
	parameter bit USE_ALT_RESET = 1'b0,
	parameter logic [CNT_W-1:0] EXT_RESET_CYCLES = EXT_RESET_CYCLES_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic backup_higher,
	input wire logic powerfail_sense_in,
	input wire ssw_strobe_t watchdog_strobe_in,
	input wire logic timebase_select,
	input wire logic timebase_input,
	input wire logic chip_enable_in_n,
	output logic reset_n,
	output logic reset,
	output logic watchdog_expired_n,
	output logic powerfail_warn_n,
	output logic chip_enable_out_n,
	output logic backup_active,
	output logic low_supply_n
);

	ssw_in_t raw;
	ssw_in_t sync1;
	ssw_in_t sync2;
	logic tb_prev;
	logic ext_sel;
	logic ext_rise;
	logic [TICK_W-1:0] tick_cnt;
	logic tick_int;
	logic tick;
	ssw_lvl_t lvl;
	ssw_lvl_t lvl_prev;
	logic wd_trans;
	logic wd_active;
	logic wd_fire;
	logic [CNT_W-1:0] wd_cnt;
	logic [CNT_W-1:0] wd_lim;
	logic [CNT_W-1:0] dly_cnt;
	logic [CNT_W-1:0] dly_lim;
	logic dly_done;
	ssw_state_t state;
	ssw_state_t next_state;
	logic next_reset_n;

	assign raw = '{supply_ok: supply_ok, backup_higher: backup_higher,
		pf_above: powerfail_sense_in, strobe: watchdog_strobe_in,
		tb_sel: timebase_select, tb_in: timebase_input};

	// Two-stage synchroniser; stage one feeds stage two only
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= SYNC_RESET;
			sync2 <= SYNC_RESET;
		end else begin
			sync1 <= raw; // [RULE22]
			sync2 <= sync1; // [RULE22]
		end
	end

	// Timebase: internal divider or edges of the external clock
	assign ext_sel = !sync2.tb_sel; // [RULE11]
	assign ext_rise = sync2.tb_in && !tb_prev;
	assign tick_int = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
	assign tick = ext_sel ? ext_rise : tick_int; // [RULE12] [RULE23]

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tb_prev <= 1'b0;
		end else begin
			tb_prev <= sync2.tb_in;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
		end else if (tick_int) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	// Timeout and delay limits per timebase
	always_comb begin
		if (ext_sel) begin
			wd_lim = EXT_WD_LONG_CYCLES; // [RULE21]
			dly_lim = EXT_RESET_CYCLES;
		end else begin
			wd_lim = sync2.tb_in ? WD_LONG_TICKS : WD_SHORT_TICKS; // [RULE13]
			dly_lim = USE_ALT_RESET ? RESET_ALT_TICKS : RESET_TICKS; // [RULE18]
		end
	end

	// Short external timeout is not selectable without a second pin; long is kept
	assign lvl = ssw_decode_strobe(sync2.strobe); // [RULE1]
	assign wd_trans = (lvl != lvl_prev); // [RULE4]
	assign wd_active = (lvl != LVL_MID) && sync2.supply_ok; // [RULE3]
	assign wd_fire = wd_active && !wd_trans && tick && (wd_cnt >= wd_lim - 1'b1); // [RULE2]

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_prev <= LVL_MID;
		end else begin
			lvl_prev <= lvl;
		end
	end

	// Counter wraps at expiry so resets repeat while the strobe is stuck
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt <= '0;
		end else if (!wd_active || wd_trans || wd_fire) begin
			wd_cnt <= '0; // [RULE4] [RULE20]
		end else if (tick) begin
			wd_cnt <= wd_cnt + 1'b1; // [RULE23]
		end
	end

	// Clearing causes win: a transition suppresses the fire in that cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_expired_n <= EXPIRED_N_RESET;
		end else if (!sync2.supply_ok) begin
			watchdog_expired_n <= 1'b1; // [RULE16]
		end else if (lvl == LVL_MID || wd_trans) begin
			watchdog_expired_n <= 1'b1; // [RULE14] [RULE15]
		end else if (wd_fire) begin
			watchdog_expired_n <= 1'b0; // [RULE2]
		end
	end

	// Reset sequencing
	assign dly_done = tick && (dly_cnt >= dly_lim - 1'b1);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_HOLD: begin
				if (sync2.supply_ok) begin
					next_state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (!sync2.supply_ok) begin
					next_state = ST_HOLD; // [RULE18]
				end else if (dly_done) begin
					next_state = ST_RUN; // [RULE18]
				end
			end
			ST_RUN: begin
				if (!sync2.supply_ok) begin
					next_state = ST_HOLD; // [RULE17]
				end else if (wd_fire) begin
					next_state = ST_REBOOT; // [RULE2] [RULE20]
				end
			end
			ST_REBOOT: begin
				if (!sync2.supply_ok) begin
					next_state = ST_HOLD;
				end else if (dly_done) begin
					next_state = ST_RUN;
				end
			end
		endcase
	end

	assign next_reset_n = (next_state == ST_RUN); // [RULE17]

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_cnt <= '0;
		end else if (next_state != state || state == ST_HOLD || state == ST_RUN) begin
			dly_cnt <= '0; // [RULE18]
		end else if (tick) begin
			dly_cnt <= dly_cnt + 1'b1; // [RULE23]
		end
	end

	// Both reset polarities from one next value keep them exact inverses
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_n <= RESET_N_RESET;
			reset <= !RESET_N_RESET;
		end else begin
			reset_n <= next_reset_n;
			reset <= !next_reset_n; // [RULE10]
		end
	end

	// Supply flags and gating
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_supply_n <= LOW_SUPPLY_N_RESET;
			powerfail_warn_n <= PF_WARN_N_RESET;
			chip_enable_out_n <= CE_OUT_N_RESET;
			backup_active <= BACKUP_RESET;
		end else begin
			low_supply_n <= sync2.supply_ok; // [RULE9]
			powerfail_warn_n <= sync2.pf_above && !sync2.backup_higher; // [RULE5] [RULE6]
			chip_enable_out_n <= chip_enable_in_n || !sync2.supply_ok
				|| sync2.backup_higher; // [RULE7]
			backup_active <= sync2.backup_higher; // [RULE8]
		end
	end

	// Checks
	sequence s_supply_lost;
		!sync2.supply_ok;
	endsequence

	sequence s_delay_ends;
		state == ST_DELAY && sync2.supply_ok && dly_done;
	endsequence

	a_reset_inverse: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE10]
		reset == !reset_n) else $error("reset polarities disagree");

	a_lowline_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
		s_supply_lost |=> !low_supply_n && !reset_n && watchdog_expired_n)
		else $error("low supply not flagged");

	a_reset_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE17]
		s_supply_lost ##1 s_supply_lost |=> !reset_n)
		else $error("reset released on low supply");

	a_expiry_low_supply: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE16]
		$fell(low_supply_n) |-> watchdog_expired_n)
		else $error("expiry flag low with low supply");

	a_release_delay: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE18]
		s_delay_ends |=> reset_n) else $error("reset not released");

	a_dropout_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE18]
		state == ST_DELAY ##0 s_supply_lost |=> state == ST_HOLD ##1 dly_cnt == '0)
		else $error("dropout did not restart delay");

	a_ce_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
		s_supply_lost |=> chip_enable_out_n) else $error("memory enable leaked");

	a_pf_backup: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE6]
		sync2.backup_higher |=> !powerfail_warn_n && backup_active)
		else $error("warning not forced by backup");

	a_pf_sense: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
		!sync2.pf_above |=> !powerfail_warn_n) else $error("power-fail missed");

	a_expiry_mid: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE15]
		lvl == LVL_MID |=> watchdog_expired_n && wd_cnt == '0)
		else $error("watchdog active at middle level");

	a_wd_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
		wd_trans |=> wd_cnt == '0 && watchdog_expired_n)
		else $error("transition did not restart watchdog");

	a_wd_expiry: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
		wd_fire && state == ST_RUN |=> !reset_n && !watchdog_expired_n)
		else $error("expiry did not assert reset");

	a_expiry_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE14]
		!watchdog_expired_n && !wd_trans && sync2.supply_ok && lvl != LVL_MID
		|=> !watchdog_expired_n) else $error("expiry flag dropped early");

	// Last short tick with a held level must expire the watchdog
	a_short_select: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
		!ext_sel && !sync2.tb_in && wd_active && !wd_trans && tick
		&& wd_cnt == WD_SHORT_TICKS - 1'b1 |-> wd_fire)
		else $error("short timeout not chosen");

	// Without an external rising edge the timeout count may only hold or restart
	a_ext_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE21] [RULE12]
		ext_sel && !ext_rise |-> wd_lim == EXT_WD_LONG_CYCLES
		##1 ($stable(wd_cnt) || wd_cnt == '0))
		else $error("external timebase not used");

endmodule : ssw_supervisor

// ===== ssw_pkg.sv
// Package for the supply supervisor and watchdog: constants, types, decode
// Function
// (RULE1) Decode strobe as low, high or middle
// (RULE2) Stuck strobe: brief reset, expiry flag low
// (RULE3) Middle strobe level disables the watchdog
// (RULE4) Every strobe transition restarts the timeout
// (RULE5) Warning low while sense below threshold
// (RULE6) Main below backup: warning held low
// (RULE7) Memory enable passes only with good supply
// (RULE8) Backup-active high while fed from backup
// (RULE9) Low-supply flag follows supply, no delay
// (RULE10) Active-high reset always inverts active-low reset
// (RULE11) Select high: internal; low: external timebase
// (RULE12) External timebase clock drives both delays
// (RULE13) Internal mode: timebase level picks short/long
// (RULE14) Expiry flag stays low until strobe transition
// (RULE15) Expiry flag high while strobe at middle
// (RULE16) Expiry flag forced high by low supply
// (RULE17) Reset held low while supply is low
// (RULE18) Release delay 50ms, dropout restarts it
// (RULE19) Host toggles strobe within each timeout
// (RULE20) Untoggled strobe repeats brief reset every timeout
// (RULE21) External timeouts: long 4096, short 1024 cycles; only the long 4096 is used
// (RULE22) Synchronise comparator and strobe inputs first
// (RULE23) Delays count ticks of the selected timebase
package ssw_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES_DEFAULT = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_MS = TICK_NS / 1000000;

	localparam int RESET_DELAY_MS = 50;
	localparam int RESET_DELAY_ALT_MS = 200;
	localparam int WD_LONG_MS = 1600;
	localparam int WD_SHORT_MS = 100;

	localparam int CNT_W = 16;
	localparam int TICK_W = 24;
	localparam logic [CNT_W-1:0] RESET_TICKS = CNT_W'(RESET_DELAY_MS / TICK_MS);
	localparam logic [CNT_W-1:0] RESET_ALT_TICKS = CNT_W'(RESET_DELAY_ALT_MS / TICK_MS);
	localparam logic [CNT_W-1:0] WD_LONG_TICKS = CNT_W'(WD_LONG_MS / TICK_MS);
	localparam logic [CNT_W-1:0] WD_SHORT_TICKS = CNT_W'(WD_SHORT_MS / TICK_MS);
	localparam logic [CNT_W-1:0] EXT_WD_LONG_CYCLES = 16'h1000;
	localparam logic [CNT_W-1:0] EXT_WD_SHORT_CYCLES = 16'h0400;
	localparam logic [CNT_W-1:0] EXT_RESET_CYCLES_DEFAULT = 16'h00C8;

	typedef struct packed {
		logic above_high;
		logic below_low;
	} ssw_strobe_t;

	typedef struct packed {
		logic supply_ok;
		logic backup_higher;
		logic pf_above;
		ssw_strobe_t strobe;
		logic tb_sel;
		logic tb_in;
	} ssw_in_t;

	typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_MID} ssw_lvl_t;
	typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN, ST_REBOOT} ssw_state_t;

	localparam ssw_in_t SYNC_RESET = '0;
	localparam logic RESET_N_RESET = 1'b0;
	localparam logic LOW_SUPPLY_N_RESET = 1'b0;
	localparam logic EXPIRED_N_RESET = 1'b1;
	localparam logic PF_WARN_N_RESET = 1'b0;
	localparam logic CE_OUT_N_RESET = 1'b1;
	localparam logic BACKUP_RESET = 1'b0;

	function automatic ssw_lvl_t ssw_decode_strobe(input ssw_strobe_t s);
		if (s.below_low && !s.above_high) begin
			return LVL_LOW;
		end else if (s.above_high && !s.below_low) begin
			return LVL_HIGH;
		end
		return LVL_MID;
	endfunction : ssw_decode_strobe

endpackage : ssw_pkg

// ===== ssw_host_model.sv
// Host processor model: watchdog strobe source and external timebase clock
`timescale 1ns/1ps
module ssw_host_model
	import ssw_pkg::*;
#(
	parameter int TOGGLE_CYCLES = 300
) (
	input wire logic sys_clk,
	input wire logic [1:0] host_mode,
	input wire logic ext_run,
	output ssw_strobe_t strobe,
	output logic tb_clk
);
	int cnt = 0;
	logic lvl = 1'b0;
	logic mid_alt = 1'b0;
	logic [1:0] div = 2'h0;

	// Mode 0 toggles, 1 holds the last level, 2 floats
	always @(posedge sys_clk) begin
		mid_alt <= ~mid_alt;
		if (host_mode == 2'h0 && cnt >= TOGGLE_CYCLES - 1) begin
			lvl <= ~lvl;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end

	// Floating seen as both codes in turn: neither is a transition
	assign strobe = (host_mode == 2'h2) ? {mid_alt, mid_alt} : {lvl, ~lvl};

	// Period of four system clocks while enabled, still otherwise
	always @(posedge sys_clk) begin
		div <= ext_run ? div + 2'h1 : 2'h0;
	end
	assign tb_clk = div[1];
endmodule : ssw_host_model

// ===== supply_supervisor_watchdog_tb.sv
// Self-checking testbench of the supply supervisor and watchdog
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module supply_supervisor_watchdog_tb
	import ssw_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_ok = 1'b0;
	logic backup_higher = 1'b0;
	logic pf = 1'b1;
	logic ce_in_n = 1'b1;
	logic timebase_select = 1'b1;
	logic long_sel = 1'b0;
	logic [1:0] host_mode = 2'h2;
	logic ext_run = 1'b0;
	logic tb_clk;
	ssw_strobe_t strobe;
	logic reset_n, reset, watchdog_expired_n, powerfail_warn_n;
	logic chip_enable_out_n, backup_active, low_supply_n;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	logic [31:0] seed = 32'd46489;
	logic [31:0] r;

	ssw_supervisor #(.TICK_CYCLES(10), .EXT_RESET_CYCLES(16'h0014)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .supply_ok(supply_ok),
		.backup_higher(backup_higher), .powerfail_sense_in(pf),
		.watchdog_strobe_in(strobe), .timebase_select(timebase_select),
		.timebase_input(timebase_select ? long_sel : tb_clk), .chip_enable_in_n(ce_in_n),
		.reset_n(reset_n), .reset(reset), .watchdog_expired_n(watchdog_expired_n),
		.powerfail_warn_n(powerfail_warn_n), .chip_enable_out_n(chip_enable_out_n),
		.backup_active(backup_active), .low_supply_n(low_supply_n));

	ssw_host_model i_host (.sys_clk(sys_clk), .host_mode(host_mode), .ext_run(ext_run),
		.strobe(strobe), .tb_clk(tb_clk));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic exp_ce(input logic ce, input logic ok, input logic bh);
		return ce | ~ok | bh;
	endfunction : exp_ce

	// Which 0 watches reset_n, otherwise the expiry flag
	task automatic wait_sig(input int which, input logic want, input int max, output int k);
		logic v;
		k = 0;
		v = ~want;
		while (v !== want && k < max) begin
			@(negedge sys_clk);
			k++;
			v = (which == 0) ? reset_n : watchdog_expired_n;
		end
	endtask : wait_sig

	task automatic end_of_test();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	initial begin
		#600000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (16) @(negedge sys_clk);
		`CHK("rst_expiry", 1'b1, watchdog_expired_n)
		@(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(negedge sys_clk);
		`CHK("low_rst", 1'b0, reset_n)
		`CHK("low_flag", 1'b0, low_supply_n)
		`CHK("low_ce", 1'b1, chip_enable_out_n)
		@(posedge sys_clk);
		supply_ok <= 1'b1;
		repeat (300) @(negedge sys_clk);
		`CHK("flag_up", 1'b1, low_supply_n)
		@(posedge sys_clk);
		supply_ok <= 1'b0;
		repeat (4) @(posedge sys_clk);
		supply_ok <= 1'b1;
		wait_sig(0, 1'b1, 600, n);
		`CHK("rel_dly", (n >= 480 && n <= 520), 1'b1)
		`CHK("inv_rst", ~reset_n, reset)
		for (int i = 0; i < 40; i++) begin
			r = xs();
			@(posedge sys_clk);
			pf <= r[0];
			backup_higher <= r[1];
			ce_in_n <= r[2];
			repeat (5) @(negedge sys_clk);
			`CHK("pf_warn", r[0] & ~r[1], powerfail_warn_n)
			`CHK("ce_out", exp_ce(r[2], 1'b1, r[1]), chip_enable_out_n)
			`CHK("backup", r[1], backup_active)
		end
		@(posedge sys_clk);
		backup_higher <= 1'b0;
		ce_in_n <= 1'b0;
		host_mode <= 2'h0;
		wait_sig(0, 1'b1, 600, n);
		repeat (3000) @(negedge sys_clk);
		`CHK("served", 1'b1, watchdog_expired_n & reset_n)
		@(posedge sys_clk);
		host_mode <= 2'h1;
		wait_sig(1, 1'b0, 1100, n);
		`CHK("short_to", (n >= 950 && n <= 1030), 1'b1)
		@(negedge sys_clk);
		`CHK("wd_rst", 1'b0, reset_n)
		wait_sig(0, 1'b1, 600, n);
		wait_sig(0, 1'b0, 1100, n);
		`CHK("repeat", 1'b0, reset_n)
		`CHK("sticky", 1'b0, watchdog_expired_n)
		@(posedge sys_clk);
		host_mode <= 2'h2;
		repeat (5) @(negedge sys_clk);
		`CHK("cleared", 1'b1, watchdog_expired_n)
		wait_sig(0, 1'b1, 600, n);
		repeat (2500) @(negedge sys_clk);
		`CHK("mid_off", 1'b1, watchdog_expired_n & reset_n)
		@(posedge sys_clk);
		long_sel <= 1'b1;
		host_mode <= 2'h1;
		wait_sig(1, 1'b0, 16200, n);
		`CHK("long_to", (n >= 15000 && n <= 16100), 1'b1)
		@(posedge sys_clk);
		supply_ok <= 1'b0;
		repeat (4) @(negedge sys_clk);
		`CHK("lo_expiry", 1'b1, watchdog_expired_n)
		`CHK("lo_ce", 1'b1, chip_enable_out_n)
		`CHK("lo_rst", 1'b0, reset_n)
		@(posedge sys_clk);
		supply_ok <= 1'b1;
		host_mode <= 2'h0;
		wait_sig(0, 1'b1, 600, n);
		@(posedge sys_clk);
		timebase_select <= 1'b0;
		ext_run <= 1'b1;
		host_mode <= 2'h1;
		wait_sig(1, 1'b0, 17000, n);
		`CHK("ext_to", (n >= 15000 && n <= 16500), 1'b1)
		@(posedge sys_clk);
		supply_ok <= 1'b0;
		host_mode <= 2'h2;
		repeat (4) @(posedge sys_clk);
		supply_ok <= 1'b1;
		wait_sig(0, 1'b1, 200, n);
		`CHK("ext_dly", (n >= 60 && n <= 110), 1'b1)
		end_of_test();
	end
endmodule : supply_supervisor_watchdog_tb
